// file: design/scd_sdram_command_decode.sv
// Behaviour
// - cs low, others high: no-operation
// - no-operation never ends a running burst
// - cs high is deselect, same as nop
// - clock gate low during a burst, or with a bank open and a command other than nop/deselect: suspend
// - suspend takes effect one clock later
// - commands ignored while suspended
// - suspend ends one clock after gate high
// - pins sampled on rising clock edges only
// - activate, read, write, mode load decode
// - read/write only to an open bank
// - burst stop only in full-page burst
// - power-down during burst becomes suspend
// - power-down entry on nop/deselect with gate fall
// - exits need gate rise with nop/deselect
// - precharge and refresh decode
// - mask high disables write data and drive
`include "scd_defines.svh"
`default_nettype none

module scd_sdram_command_decode
  import scd_pkg::*;
#(
  parameter int NUM_BANKS = `SCD_NUM_BANKS,
  parameter int ADDR_W    = `SCD_ADDR_W,
  parameter int BURST_LEN = `SCD_BURST_LEN
)
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  // command pins, strobes active low; the clock gate and data mask active high
  input  wire logic                   sel_n,
  input  wire logic                   row_strobe_n,
  input  wire logic                   col_strobe_n,
  input  wire logic                   wr_strobe_n,
  input  wire logic                   bank_sel_lo,
  input  wire logic                   bank_sel_hi,
  input  wire logic [ADDR_W-1:0]      addr,
  input  wire logic                   clk_gate_sample_now,
  input  wire logic                   data_mask,
  // mode from the mode register, full-page burst selects burst stop use
  input  wire logic                   full_page_mode,
  // decoded command, one-cycle pulse per accepted edge
  output logic [9:0]                  cmd_code,
  output logic                        cmd_valid,
  output logic [`SCD_BANK_W-1:0]      cmd_bank,
  output logic                        cmd_auto_close,
  output logic                        cmd_all_banks,
  output logic [ADDR_W-1:0]           cmd_addr,
  // device state
  output logic [NUM_BANKS-1:0]        bank_open,
  output logic                        burst_active,
  output logic [3:0]                  dev_state,
  output logic                        int_clk_en,
  output logic                        data_enable
);

  // registered copies of the pins; the far side is logic on clk_sys
  logic                    sel_n_q;               // pin stage
  logic                    row_n_q;               // pin stage
  logic                    col_n_q;               // pin stage
  logic                    wr_n_q;                // pin stage
  logic [`SCD_BANK_W-1:0]  bank_q;                // bank select stage
  logic [ADDR_W-1:0]       addr_q;                // address stage
  logic                    gate_now_q;            // gate at this edge
  logic                    clk_gate_sample_prev;  // gate one edge back
  logic                    mask_q;                // mask stage

  // state registers
  // the burst counter is 8 bits so a longer burst length still fits
  scd_state_t              state_q;               // power/clock state
  scd_state_t              state_d;               // its next value
  logic [NUM_BANKS-1:0]    banks_q;               // open bank vector
  logic [NUM_BANKS-1:0]    banks_d;               // its next value
  logic [7:0]              burst_cnt_q;           // beats left in burst
  logic [7:0]              burst_cnt_d;           // its next value
  logic                    full_q;                // full-page burst running
  logic                    full_d;                // its next value
  scd_cmd_t                cmd_q;                 // decoded command
  scd_cmd_t                cmd_d;                 // its next value
  logic                    valid_q;               // command accepted
  logic                    valid_d;               // its next value

  // bank index from the two select pins
  // one-hot mask of the addressed bank, shared by decode and bookkeeping
  function automatic logic [NUM_BANKS-1:0] bank_onehot(
    input logic [`SCD_BANK_W-1:0] b
  );
    logic [NUM_BANKS-1:0] v;
    v = '0;
    v[b] = 1'b1;
    return v;
  endfunction

  // capture every pin on the rising edge only
  // the controller shares clk_sys, so one stage is enough and no
  // synchroniser is needed; a foreign controller would need one
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      // pins rest on a deselect with the gate high, so no false edge
      sel_n_q              <= 1'b1;
      row_n_q              <= 1'b1;
      col_n_q              <= 1'b1;
      wr_n_q               <= 1'b1;
      bank_q               <= '0;
      addr_q               <= '0;
      gate_now_q           <= 1'b1;
      clk_gate_sample_prev <= 1'b1;
      mask_q               <= 1'b1;
    end
    else
    begin
      // both gate stages feed the edge detectors below
      sel_n_q              <= sel_n;
      row_n_q              <= row_strobe_n;
      col_n_q              <= col_strobe_n;
      wr_n_q               <= wr_strobe_n;
      bank_q               <= {bank_sel_hi, bank_sel_lo};
      addr_q               <= addr;
      gate_now_q           <= clk_gate_sample_now;
      clk_gate_sample_prev <= gate_now_q;
      mask_q               <= data_mask;
    end
  end

  // raw encodings of the sampled pins
  // deselect ignores the three strobes, so it is tested on select alone
  wire enc_desel  = sel_n_q;
  wire enc_nop    = !sel_n_q && row_n_q && col_n_q && wr_n_q;
  wire idle_enc   = enc_desel || enc_nop;
  wire enc_act    = !sel_n_q && !row_n_q && col_n_q && wr_n_q;
  wire enc_read   = !sel_n_q && row_n_q && !col_n_q && wr_n_q;
  wire enc_write  = !sel_n_q && row_n_q && !col_n_q && !wr_n_q;
  wire enc_mode   = !sel_n_q && !row_n_q && !col_n_q && !wr_n_q;
  wire enc_prech  = !sel_n_q && !row_n_q && col_n_q && !wr_n_q;
  wire enc_ref    = !sel_n_q && !row_n_q && !col_n_q && wr_n_q;
  wire enc_bstop  = !sel_n_q && row_n_q && col_n_q && !wr_n_q;
  wire auto_bit   = addr_q[`SCD_AUTO_CLOSE_BIT];
  // bank addressed by the command and the open-bank summaries
  wire [NUM_BANKS-1:0] sel_bank = bank_onehot(bank_q);
  wire bank_is_open = |(banks_q & sel_bank);
  wire any_open   = |banks_q;
  wire all_idle   = !any_open;
  // a finite burst counts beats, a full-page burst runs until stopped
  wire in_burst   = (burst_cnt_q != 8'h00) || full_q;

  // gate transitions between the previous and present edges
  // both stages reset high, matching the idle pin level
  wire gate_fall  = clk_gate_sample_prev && !gate_now_q;
  wire gate_rise  = !clk_gate_sample_prev && gate_now_q;
  // the present gate level does not matter here: a command with the
  // gate falling is still taken, which is how self-refresh is entered
  // a command is live only while the gate was high last edge
  wire live       = (state_q == SCD_ST_RUN) && clk_gate_sample_prev;

  // next state of the power/clock machine
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      SCD_ST_RUN:
      begin
        // refresh with the gate falling and all banks closed
        if (gate_fall && enc_ref && gate_now_q == 1'b0 && all_idle)
          state_d = SCD_ST_SREF;
        // nop or deselect with no burst parks the device
        else if (gate_fall && idle_enc && !in_burst)
          state_d = SCD_ST_PDOWN;
        // a bank open or a burst turns the fall into a suspend
        else if (gate_fall && (any_open || in_burst))
          state_d = SCD_ST_SUSPEND;
        // any other command with the gate falling and nothing open
        else if (gate_fall)
          state_d = SCD_ST_PDOWN;
      end
      SCD_ST_SUSPEND:
      begin
        // any level on the pins ends suspend once the gate is back
        // commands meanwhile are dropped by the decode, not here
        if (gate_rise)
          state_d = SCD_ST_RUN;
      end
      SCD_ST_PDOWN:
      begin
        // a rise with any other command keeps the device parked;
        // the controller owes a nop on the rise edge
        if (gate_rise && idle_enc)
          state_d = SCD_ST_RUN;
      end
      SCD_ST_SREF:
      begin
        // the refresh timer itself is outside this block
        if (gate_rise && idle_enc)
          state_d = SCD_ST_RUN;
      end
    endcase
  end

  // command decode, banks and burst bookkeeping
  always_comb
  begin
    cmd_d       = SCD_CMD_NONE;
    valid_d     = 1'b0;
    banks_d     = banks_q;
    burst_cnt_d = burst_cnt_q;
    full_d      = full_q;
    // a running burst counts down while the clock is not suspended
    // suspend freezes the count, so the burst resumes where it stopped
    if (state_q == SCD_ST_RUN && burst_cnt_q != 8'h00)
      burst_cnt_d = burst_cnt_q - 8'h01;
    // suspend and power modes drop every command
    if (live)
    begin
      // accepted unless a branch below refuses it
      valid_d = 1'b1;
      if (idle_enc)
        cmd_d = SCD_CMD_NOP;          // burst keeps going
      // activate opens a closed bank only
      else if (enc_act && !bank_is_open)
      begin
        cmd_d   = SCD_CMD_ACTIVATE;
        banks_d = banks_q | sel_bank;
      end
      // read or write reaches an open bank only
      else if ((enc_read || enc_write) && bank_is_open)
      begin
        cmd_d = enc_read ? SCD_CMD_READ : SCD_CMD_WRITE;
        // full page runs until a stop or precharge; a finite burst
        // counts its beats down to zero
        full_d = full_page_mode && !auto_bit;
        burst_cnt_d = full_page_mode ? 8'h00 : 8'(BURST_LEN - 1);
        // bookkeeping closes the bank at once, not after the burst
        if (auto_bit)
          banks_d = banks_q & ~sel_bank;
      end
      // mode load only with every bank closed
      else if (enc_mode && all_idle)
        cmd_d = SCD_CMD_MODE;
      // precharge of one bank or, with the address bit, of all
      else if (enc_prech)
      begin
        cmd_d   = SCD_CMD_PRECH;
        banks_d = auto_bit ? '0 : (banks_q & ~sel_bank);
        // precharge also ends any full-page burst
        full_d  = 1'b0;
      end
      // refresh with all banks closed; the gate picks auto or self
      else if (enc_ref && all_idle)
        cmd_d = gate_now_q ? SCD_CMD_AREF : SCD_CMD_SREF;
      // burst stop only while a full-page burst runs
      else if (enc_bstop && full_q)
      begin
        cmd_d  = SCD_CMD_BSTOP;
        // the bank stays open after a burst stop
        full_d = 1'b0;
      end
      // anything else is refused and leaves no trace
      else
        valid_d = 1'b0;
    end
  end

  // state and bookkeeping registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      // the device wakes running with every bank closed
      state_q     <= SCD_ST_RUN;
      banks_q     <= `SCD_BANKS_RST;
      burst_cnt_q <= 8'h00;
      full_q      <= 1'b0;
      cmd_q       <= SCD_CMD_NONE;
      valid_q     <= 1'b0;
    end
    else
    begin
      // state moves one clock after the gate level is registered
      state_q     <= state_d;
      banks_q     <= banks_d;
      burst_cnt_q <= burst_cnt_d;
      full_q      <= full_d;
      cmd_q       <= cmd_d;
      valid_q     <= valid_d;
    end
  end

  // command outputs held in flops alongside the decode
  // companions are captured every edge; they mean something only
  // alongside cmd_valid, so consumers must qualify them with it
  logic [`SCD_BANK_W-1:0] bank_out_q;   // bank of the command
  logic                   auto_out_q;   // auto-close request
  logic                   all_out_q;    // precharge-all flag
  logic [ADDR_W-1:0]      addr_out_q;   // address of the command
  logic                   data_en_q;    // write/drive enable

  // data enable follows the mask only with a bank open
  // mask and commands both take two edges, so they line up
  // with every bank closed there is nothing to write or drive
  wire data_en_d = any_open && !mask_q;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      bank_out_q <= '0;
      auto_out_q <= 1'b0;
      all_out_q  <= 1'b0;
      addr_out_q <= '0;
      data_en_q  <= 1'b0;
    end
    else
    begin
      bank_out_q <= bank_q;
      auto_out_q <= auto_bit && (enc_read || enc_write);
      all_out_q  <= auto_bit && enc_prech;
      addr_out_q <= addr_q;
      data_en_q  <= data_en_d;
    end
  end

  // outputs
  // burst_active and int_clk_en are plain decodes of registers
  assign cmd_code       = cmd_q;
  assign cmd_valid      = valid_q;
  assign cmd_bank       = bank_out_q;
  assign cmd_auto_close = auto_out_q;
  assign cmd_all_banks  = all_out_q;
  assign cmd_addr       = addr_out_q;
  assign bank_open      = banks_q;
  assign burst_active   = (burst_cnt_q != 8'h00) || full_q;
  assign dev_state      = state_q;
  assign int_clk_en     = (state_q == SCD_ST_RUN);
  assign data_enable    = data_en_q;

endmodule

`default_nettype wire

// file: design/scd_defines.svh
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

// bank count and bank select width
`define SCD_NUM_BANKS       4
`define SCD_BANK_W          2
// address width and the auto-close bit position
`define SCD_ADDR_W          11
`define SCD_AUTO_CLOSE_BIT  10
// reset value of the bank-open vector
`define SCD_BANKS_RST       4'h0
// burst length used when none is programmed
`define SCD_BURST_LEN       4

`endif

// file: design/scd_pkg.sv
`default_nettype none

package scd_pkg;

  // decoded command, one-hot
  typedef enum logic [9:0] {
    SCD_CMD_NOP      = 10'h001,
    SCD_CMD_ACTIVATE = 10'h002,
    SCD_CMD_READ     = 10'h004,
    SCD_CMD_WRITE    = 10'h008,
    SCD_CMD_PRECH    = 10'h010,
    SCD_CMD_MODE     = 10'h020,
    SCD_CMD_AREF     = 10'h040,
    SCD_CMD_SREF     = 10'h080,
    SCD_CMD_BSTOP    = 10'h100,
    SCD_CMD_NONE     = 10'h200
  } scd_cmd_t;

  // device power/clock state, one-hot
  typedef enum logic [3:0] {
    SCD_ST_RUN     = 4'h1,
    SCD_ST_SUSPEND = 4'h2,
    SCD_ST_PDOWN   = 4'h4,
    SCD_ST_SREF    = 4'h8
  } scd_state_t;

endpackage

`default_nettype wire

// file: verif/scd_ctrl_model.sv
`default_nettype none

// controller model: one command per call, a nop on every other edge
module scd_ctrl_model
(
  // clock
  input  wire logic        clk_sys,
  // command pins
  output var  logic        sel_n,
  output var  logic        row_strobe_n,
  output var  logic        col_strobe_n,
  output var  logic        wr_strobe_n,
  output var  logic [1:0]  bank_sel,
  output var  logic [10:0] addr,
  output var  logic        clk_gate_sample_now
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle on a nop with the gate high
  initial
  begin
    {sel_n, row_strobe_n, col_strobe_n, wr_strobe_n} = 4'h7;
    bank_sel = 2'h0;
    addr = 11'h000;
    clk_gate_sample_now = 1'b1;
  end

  // drive one encoding, then fall back to a nop; g holds from then on
  task automatic send(logic [3:0] p, logic [1:0] b, logic [10:0] a,
                      logic g);
    @(posedge clk_sys);
    {sel_n, row_strobe_n, col_strobe_n, wr_strobe_n} <= p;
    bank_sel <= b;
    addr <= a;
    clk_gate_sample_now <= g;
    @(posedge clk_sys);
    // nop also follows a gate rise out of power-down
    {sel_n, row_strobe_n, col_strobe_n, wr_strobe_n} <= 4'h7;
    addr <= ~a;
  endtask
endmodule

`default_nettype wire

// file: verif/scd_cmd_decode_props.sv
`default_nettype none

// port checks; a command shows its result two edges after its pins
module scd_cmd_props
  import scd_pkg::*;
#(
  parameter int ADDR_W = 11
)
(
  // clock, reset and command pins
  input wire logic              clk_sys,
  input wire logic              resetn,
  input wire logic              sel_n,
  input wire logic              row_strobe_n,
  input wire logic              col_strobe_n,
  input wire logic              wr_strobe_n,
  input wire logic              bank_sel_lo,
  input wire logic              bank_sel_hi,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              clk_gate_sample_now,
  input wire logic              data_mask,
  // decoder outputs
  input wire logic [9:0]        cmd_code,
  input wire logic              cmd_valid,
  input wire logic [1:0]        cmd_bank,
  input wire logic              cmd_all_banks,
  input wire logic [3:0]        bank_open,
  input wire logic              burst_active,
  input wire logic [3:0]        dev_state,
  input wire logic              data_enable
);
  // pins packed for history lookups
  wire logic [3:0] pins = {sel_n, row_strobe_n, col_strobe_n, wr_strobe_n};
  wire logic [1:0] bsel = {bank_sel_hi, bank_sel_lo};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_sel;
    cmd_valid |-> $past(clk_gate_sample_now, 3)
      && (!$past(sel_n, 2) || cmd_code == SCD_CMD_NOP);
  endproperty
  a_sel: assert property (p_sel)
    else $error("command taken without select");
  property p_act;
    cmd_valid && cmd_code == SCD_CMD_ACTIVATE
      |-> $past(pins, 2) == 4'h3 && bank_open[cmd_bank];
  endproperty
  a_act: assert property (p_act)
    else $error("activate wrong");
  property p_rw;
    cmd_valid && (cmd_code == SCD_CMD_READ || cmd_code == SCD_CMD_WRITE)
      |-> cmd_bank == $past(bsel, 2) && ($past(bank_open) >> cmd_bank & 4'h1);
  endproperty
  a_rw: assert property (p_rw)
    else $error("access to a closed bank");
  property p_pre;
    cmd_valid && cmd_code == SCD_CMD_PRECH |-> cmd_all_banks ==
      $past(addr[10], 2) && (!cmd_all_banks || bank_open == 4'h0);
  endproperty
  a_pre: assert property (p_pre)
    else $error("precharge wrong");
  // a gate fall during a burst must suspend, one clock late
  property p_susp;
    $fell(clk_gate_sample_now) && burst_active && dev_state == SCD_ST_RUN
      |-> ##1 dev_state == SCD_ST_RUN ##1 dev_state == SCD_ST_SUSPEND;
  endproperty
  a_susp: assert property (p_susp)
    else $error("suspend entry timing");
  property p_resume;
    $rose(clk_gate_sample_now) && dev_state == SCD_ST_SUSPEND
      |-> ##1 dev_state == SCD_ST_SUSPEND ##1 dev_state == SCD_ST_RUN;
  endproperty
  a_resume: assert property (p_resume)
    else $error("suspend exit timing");
  property p_frozen;
    dev_state != SCD_ST_RUN |=> !cmd_valid;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("command taken while gated");
  property p_mask;
    data_mask [*3] |-> !data_enable;
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask did not disable data");
  property p_stop;
    cmd_valid && cmd_code == SCD_CMD_BSTOP
      |-> $past(burst_active) && $past(pins, 2) == 4'h6;
  endproperty
  a_stop: assert property (p_stop)
    else $error("burst stop outside a burst");
endmodule

bind scd_sdram_command_decode scd_cmd_props #(.ADDR_W(ADDR_W)) chk_u (
  .clk_sys, .resetn, .sel_n, .row_strobe_n, .col_strobe_n, .wr_strobe_n,
  .bank_sel_lo, .bank_sel_hi, .addr, .clk_gate_sample_now, .data_mask,
  .cmd_code, .cmd_valid, .cmd_bank, .cmd_all_banks, .bank_open,
  .burst_active, .dev_state, .data_enable);

`default_nettype wire

// file: verif/tb_top.sv
`default_nettype none

module tb_top
  import scd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // encodings of select, row, column, write strobe
  localparam logic [3:0] NOP = 4'h7, DSL = 4'hf, ACT = 4'h3, RD = 4'h5;
  localparam logic [3:0] WR = 4'h4, PRE = 4'h2, MLD = 4'h0, RFS = 4'h1;
  localparam logic [3:0] BST = 4'h6;

  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        data_mask = 1'b0;
  logic        full_page_mode = 1'b0;
  logic        sel_n, row_strobe_n, col_strobe_n, wr_strobe_n;
  logic        clk_gate_sample_now, cmd_valid, cmd_auto_close;
  logic        cmd_all_banks, burst_active, int_clk_en, data_enable;
  logic [1:0]  bank_sel, cmd_bank;
  logic [10:0] addr, cmd_addr;
  logic [9:0]  cmd_code;
  logic [3:0]  bank_open, dev_state;
  int          bad_count = 0;
  int          total_checks = 0;

  always #25 clk_sys = ~clk_sys;

  scd_ctrl_model pm_u (.clk_sys, .sel_n, .row_strobe_n, .col_strobe_n,
    .wr_strobe_n, .bank_sel, .addr, .clk_gate_sample_now);

  scd_sdram_command_decode dut_u (.clk_sys, .resetn, .sel_n,
    .row_strobe_n, .col_strobe_n, .wr_strobe_n,
    .bank_sel_lo(bank_sel[0]), .bank_sel_hi(bank_sel[1]), .addr,
    .clk_gate_sample_now, .data_mask, .full_page_mode, .cmd_code,
    .cmd_valid, .cmd_bank, .cmd_auto_close, .cmd_all_banks,
    .cmd_addr, .bank_open, .burst_active, .dev_state, .int_clk_en,
    .data_enable);

  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // one command, then look once its two-edge latency has passed
  task automatic go(logic [3:0] p, logic [1:0] b, logic [10:0] a, logic g);
    pm_u.send(p, b, a, g);
    @(posedge clk_sys);
    #1;
  endtask

  // state changes are waited for under a bound
  task automatic wait_st(string n, logic [3:0] s);
    repeat (6)
    begin
      if (dev_state === s)
        break;
      @(posedge clk_sys);
      #1;
    end
    chk(n, dev_state, s);
  endtask

  task automatic t_decode();
    go(ACT, 2'h2, 11'h123, 1'b1);
    chk("act", {cmd_code, bank_open}, {SCD_CMD_ACTIVATE, 4'h4});
    chk("act addr", cmd_addr, 11'h123);
    go(RD, 2'h1, 11'h000, 1'b1);
    chk("rd closed", cmd_valid, 1'b0);
    go(RD, 2'h2, 11'h000, 1'b1);
    chk("rd", {cmd_code, cmd_bank}, {SCD_CMD_READ, 2'h2});
    chk("rd burst", burst_active, 1'b1);
    go(WR, 2'h2, 11'h400, 1'b1);
    chk("wr", {cmd_code, cmd_auto_close, bank_open},
        {SCD_CMD_WRITE, 1'b1, 4'h0});
    repeat (2) @(posedge clk_sys);
    #1;
    chk("bl run", burst_active, 1'b1);
    @(posedge clk_sys);
    #1;
    chk("bl end", burst_active, 1'b0);
    go(4'hb, 2'h0, 11'h000, 1'b1);
    chk("desel", {cmd_valid, cmd_code, bank_open},
        {1'b1, SCD_CMD_NOP, 4'h0});
    go(MLD, 2'h0, 11'h000, 1'b1);
    chk("mode", cmd_code, SCD_CMD_MODE);
    go(RFS, 2'h0, 11'h000, 1'b1);
    chk("aref", cmd_code, SCD_CMD_AREF);
    go(ACT, 2'h0, 11'h000, 1'b1);
    go(ACT, 2'h3, 11'h000, 1'b1);
    go(PRE, 2'h0, 11'h000, 1'b1);
    chk("pre", {cmd_code, cmd_all_banks, bank_open},
        {SCD_CMD_PRECH, 1'b0, 4'h8});
    go(PRE, 2'h1, 11'h400, 1'b1);
    chk("pre all", {cmd_all_banks, bank_open}, {1'b1, 4'h0});
    $display("decode test done");
  endtask

  task automatic t_susp();
    @(posedge clk_sys);
    full_page_mode <= 1'b1;
    go(ACT, 2'h1, 11'h000, 1'b1);
    go(RD, 2'h1, 11'h000, 1'b1);
    go(NOP, 2'h0, 11'h000, 1'b1);
    chk("burst", burst_active, 1'b1);
    go(NOP, 2'h0, 11'h000, 1'b0);
    wait_st("susp", SCD_ST_SUSPEND);
    chk("clk off", int_clk_en, 1'b0);
    go(ACT, 2'h0, 11'h000, 1'b0);
    chk("ignored", bank_open, 4'h2);
    go(NOP, 2'h0, 11'h000, 1'b1);
    wait_st("resume", SCD_ST_RUN);
    chk("frozen", burst_active, 1'b1);
    go(BST, 2'h1, 11'h000, 1'b1);
    chk("stop", {cmd_valid, cmd_code}, {1'b1, SCD_CMD_BSTOP});
    go(BST, 2'h1, 11'h000, 1'b1);
    chk("stray stop", cmd_valid, 1'b0);
    go(PRE, 2'h0, 11'h400, 1'b1);
    @(posedge clk_sys);
    full_page_mode <= 1'b0;
    $display("suspend test done");
  endtask

  task automatic t_power();
    go(DSL, 2'h0, 11'h000, 1'b0);
    wait_st("pdown", SCD_ST_PDOWN);
    go(ACT, 2'h0, 11'h000, 1'b0);
    chk("pd ignore", bank_open, 4'h0);
    go(NOP, 2'h0, 11'h000, 1'b1);
    wait_st("pd exit", SCD_ST_RUN);
    // every bank is closed here, as self-refresh entry requires
    go(RFS, 2'h0, 11'h000, 1'b0);
    chk("sref", {cmd_valid, cmd_code}, {1'b1, SCD_CMD_SREF});
    wait_st("sref st", SCD_ST_SREF);
    go(DSL, 2'h0, 11'h000, 1'b1);
    wait_st("sref exit", SCD_ST_RUN);
    $display("power test done");
  endtask

  task automatic t_mask();
    go(ACT, 2'h0, 11'h000, 1'b1);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("dq on", data_enable, 1'b1);
    @(posedge clk_sys);
    data_mask <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("dq off", data_enable, 1'b0);
    $display("mask test done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    t_decode();
    t_susp();
    t_power();
    t_mask();
    report_and_stop();
  end

  // the tests need about a hundred cycles; this is far beyond that
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    report_and_stop();
  end
endmodule

`default_nettype wire
